// ---- common/tpsu_map.vh ----
// Register map, field positions, reset values and event codes of the
// tile performance sampling unit.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
//
// Operation
// - Report monitoring version 3 and count model-specific events too.
// - Two general counters and three fixed-function counters.
// - Each general counter counts what its event select picks.
// - Any-thread only for fixed events and the two general cycle events.
// - Capability register reports record format 2 in bits 11:8.
// - Selected memory events also record the data linear address.
// - Private off-core response registers, each tied to one unit mask of event B7H.
// - Latency mode pairs an occurrence counter with an outstanding-cycles counter.
// - Only general counter 0 produces sampling records.
// - Records go to the save area, holding state after the eventing instruction.
// - Branch retired event C4H with its unit masks, no address.
// - Branch mispredict event C5H with its unit masks, no address.
// - Memory uop event 04H masks 02H, 04H, 08H capture address.
// - Recycle queue event 03H masks 01H and 08H capture address.
// - Every record field is written as 64 bits.
// - Flags 00H, pointer 08H, sixteen registers 10H to 88H in order.
// - Global overflow status at record byte 90H.
`ifndef TPSU_MAP_VH
`define TPSU_MAP_VH
// Register byte offsets
`define TPSU_EVSEL0 8'h00
`define TPSU_EVSEL1 8'h04
`define TPSU_GCTR0 8'h08
`define TPSU_GCTR1 8'h0c
`define TPSU_FCTR0 8'h10
`define TPSU_FCTR1 8'h14
`define TPSU_FCTR2 8'h18
`define TPSU_FCTL 8'h1c
`define TPSU_GSTAT 8'h20
`define TPSU_SMPEN 8'h24
`define TPSU_CAP 8'h28
`define TPSU_VERS 8'h2c
`define TPSU_RSP0 8'h30
`define TPSU_RSP1 8'h34
`define TPSU_LATC 8'h38
`define TPSU_DSBASE 8'h3c
`define TPSU_RECST 8'h40
// Field layouts and masks
`define TPSU_EVS_MASK 32'h0060ffff
`define TPSU_EVS_ANY 21
`define TPSU_EVS_EN 22
`define TPSU_FCTL_MASK 32'h00000333
`define TPSU_CAP_VAL 32'h00000200
`define TPSU_VERS_VAL 32'h00030203
`define TPSU_RESET32 32'h00000000
// Event codes and unit masks
`define TPSU_EV_CYC 8'h3c
`define TPSU_UM_CORE 8'h00
`define TPSU_UM_REF 8'h01
`define TPSU_EV_OFFC 8'hb7
`define TPSU_UM_RSP0 8'h01
`define TPSU_UM_RSP1 8'h02
`define TPSU_EV_BRRET 8'hc4
`define TPSU_EV_BRMIS 8'hc5
`define TPSU_EV_MEMU 8'h04
`define TPSU_EV_RECQ 8'h03
// Record layout: 24 fields of 8 bytes
`define TPSU_REC_BYTES 32'h000000c0
`define TPSU_FLD_LAST 5'h17
`define TPSU_FLD_GSTAT 5'h12
`define TPSU_FLD_DLA 5'h13
`define TPSU_FLD_EIP 5'h16
`define TPSU_FLD_ARCH 5'h12
`endif

// ---- rtl/tpsu_ctr.v ----
// One 32-bit event counter with software load and overflow strobe.
// Assumes the increment arrives from same-clock logic.
`timescale 1ns/1ps
module tpsu_ctr (
   input wire clk_i,
   input wire srst_i,
   input wire wr_i,
   input wire [31:0] wdata_i,
   input wire [3:0] inc_i,
   output reg [31:0] count_o,
   output reg ovf_o
);
   wire [32:0] sum;

   // Carry out of the adder marks a wrap past all ones
   assign sum = {1'b0, count_o} + {29'h0, inc_i};

   // Software load wins and never reports an overflow
   always @(posedge clk_i) begin
      if (srst_i) begin
         count_o <= 32'h00000000;
         ovf_o <= 1'b0;
      end else if (wr_i) begin
         count_o <= wdata_i;
         ovf_o <= 1'b0;
      end else begin
         count_o <= sum[31:0];
         ovf_o <= sum[32];
      end
   end
endmodule

// ---- rtl/tpsu_top.v ----
// Tile performance sampling unit: counters, event qualification,
// off-core response filtering, latency pairing and sample records.
// Assumes core event strobes on clk_i and a memory port that holds
// the architectural state stable while a record is written.
`timescale 1ns/1ps
`include "tpsu_map.vh"
module tpsu_top (
   input wire clk_i,
   input wire srst_i,
   input wire [7:0] paddr_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output reg pslverr_o,
   input wire ev_valid_i,
   input wire [7:0] ev_code_i,
   input wire [7:0] ev_umask_i,
   input wire [15:0] ev_req_type_i,
   input wire [63:0] ev_ip_i,
   input wire [63:0] ev_dla_i,
   input wire [3:0] outst_i,
   input wire instr_ret_i,
   input wire core_cyc_i,
   input wire ref_cyc_i,
   input wire sib_instr_ret_i,
   input wire sib_core_cyc_i,
   input wire sib_ref_cyc_i,
   output reg [4:0] st_sel_o,
   input wire [63:0] st_data_i,
   output wire mem_req_o,
   output reg [31:0] mem_addr_o,
   output reg [63:0] mem_wdata_o,
   input wire mem_ack_i,
   output wire rec_busy_o
);
   localparam ST_IDLE = 2'd0;
   localparam ST_LOAD = 2'd1;
   localparam ST_WR = 2'd2;

   reg [31:0] evsel0, evsel1, fctl, rsp0, rsp1, ds_base, rd_val;
   reg [15:0] rec_idx;
   reg [4:0] gstat, next_gstat, snap_stat, fld;
   reg [3:0] inc0, inc1, finc0, finc1, finc2;
   reg [1:0] state;
   reg smp_en, lat_en, smp_ok_q, dla_ok_q, rd_err;
   reg [63:0] eip_q, dla_q, snap_ip, snap_dla, fld_data;
   wire [31:0] gc0, gc1, fc0, fc1, fc2, rec_off;
   wire [4:0] ovf;
   wire wr_en, rd_setup, off_ok, match0, match1, hit0, smp_hit, dla_hit, trig;

   ////////////////////////////////////////////////////////////////////
   // Event qualification

   // Cycle events take the sibling thread only when any-thread is set
   function [3:0] cyc_inc;
      input [31:0] sel;
      begin
         cyc_inc = 4'h0;
         if (sel[15:8] == `TPSU_UM_CORE) begin
            cyc_inc = {3'b000, core_cyc_i};
            if (sel[`TPSU_EVS_ANY] && sib_core_cyc_i)
               cyc_inc = cyc_inc + 4'h1;
         end else if (sel[15:8] == `TPSU_UM_REF) begin
            cyc_inc = {3'b000, ref_cyc_i};
            if (sel[`TPSU_EVS_ANY] && sib_ref_cyc_i)
               cyc_inc = cyc_inc + 4'h1;
         end
      end
   endfunction

   // Off-core code also needs a request type hit in the response register
   // its unit mask names; plain assigns keep every input in the sensitivity
   assign off_ok = (ev_umask_i == `TPSU_UM_RSP0 && |(ev_req_type_i & rsp0[15:0])) ||
      (ev_umask_i == `TPSU_UM_RSP1 && |(ev_req_type_i & rsp1[15:0]));
   // One count for an event matching both code and unit mask
   assign match0 = ev_valid_i && {ev_umask_i, ev_code_i} == evsel0[15:0] &&
      (ev_code_i != `TPSU_EV_OFFC || off_ok);
   assign match1 = ev_valid_i && {ev_umask_i, ev_code_i} == evsel1[15:0] &&
      (ev_code_i != `TPSU_EV_OFFC || off_ok);

   // Sampling-capable event list; the second bit marks address capture
   function [1:0] smp_class;
      input [7:0] code;
      input [7:0] um;
      begin
         smp_class = 2'b00;
         case (code)
            `TPSU_EV_BRRET: begin
               if (um == 8'h00 || um == 8'h7e || um == 8'hfe || um == 8'hf9 ||
                   um == 8'hfd || um == 8'hfb || um == 8'heb || um == 8'hbf ||
                   um == 8'hf7)
                  smp_class = 2'b01;
            end
            `TPSU_EV_BRMIS: begin
               if (um == 8'h00 || um == 8'h7e || um == 8'hfe || um == 8'hfb ||
                   um == 8'heb || um == 8'hf7)
                  smp_class = 2'b01;
            end
            `TPSU_EV_MEMU: begin
               if (um == 8'h02 || um == 8'h04 || um == 8'h08)
                  smp_class = 2'b11;
            end
            `TPSU_EV_RECQ: begin
               if (um == 8'h01 || um == 8'h08)
                  smp_class = 2'b11;
            end
            default: smp_class = 2'b00;
         endcase
      end
   endfunction

   assign hit0 = match0 && evsel0[`TPSU_EVS_EN];
   assign smp_hit = smp_class(evsel0[7:0], evsel0[15:8]) != 2'b00;
   assign dla_hit = smp_class(evsel0[7:0], evsel0[15:8]) == 2'b11;

   // Increments for every counter
   always @* begin
      inc0 = 4'h0;
      inc1 = 4'h0;
      if (evsel0[`TPSU_EVS_EN]) begin
         if (evsel0[7:0] == `TPSU_EV_CYC)
            inc0 = cyc_inc(evsel0);
         else
            inc0 = {3'b000, hit0};
      end
      // Latency mode turns counter 1 into an outstanding-request adder
      if (lat_en && evsel1[`TPSU_EVS_EN]) begin
         inc1 = outst_i;
      end else if (evsel1[`TPSU_EVS_EN]) begin
         if (evsel1[7:0] == `TPSU_EV_CYC)
            inc1 = cyc_inc(evsel1);
         else
            inc1 = {3'b000, match1};
      end
      finc0 = {3'b000, fctl[0] & instr_ret_i};
      finc1 = {3'b000, fctl[4] & core_cyc_i};
      finc2 = {3'b000, fctl[8] & ref_cyc_i};
      if (fctl[0] && fctl[1] && sib_instr_ret_i)
         finc0 = finc0 + 4'h1;
      if (fctl[4] && fctl[5] && sib_core_cyc_i)
         finc1 = finc1 + 4'h1;
      if (fctl[8] && fctl[9] && sib_ref_cyc_i)
         finc2 = finc2 + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////
   // Counters

   assign wr_en = psel_i && penable_i && pwrite_i;

   // Two general and three fixed counters share one counter module
   tpsu_ctr u_gc0 (.clk_i(clk_i), .srst_i(srst_i),
      .wr_i(wr_en && paddr_i == `TPSU_GCTR0), .wdata_i(pwdata_i),
      .inc_i(inc0), .count_o(gc0), .ovf_o(ovf[0]));
   tpsu_ctr u_gc1 (.clk_i(clk_i), .srst_i(srst_i),
      .wr_i(wr_en && paddr_i == `TPSU_GCTR1), .wdata_i(pwdata_i),
      .inc_i(inc1), .count_o(gc1), .ovf_o(ovf[1]));
   tpsu_ctr u_fc0 (.clk_i(clk_i), .srst_i(srst_i),
      .wr_i(wr_en && paddr_i == `TPSU_FCTR0), .wdata_i(pwdata_i),
      .inc_i(finc0), .count_o(fc0), .ovf_o(ovf[2]));
   tpsu_ctr u_fc1 (.clk_i(clk_i), .srst_i(srst_i),
      .wr_i(wr_en && paddr_i == `TPSU_FCTR1), .wdata_i(pwdata_i),
      .inc_i(finc1), .count_o(fc1), .ovf_o(ovf[3]));
   tpsu_ctr u_fc2 (.clk_i(clk_i), .srst_i(srst_i),
      .wr_i(wr_en && paddr_i == `TPSU_FCTR2), .wdata_i(pwdata_i),
      .inc_i(finc2), .count_o(fc2), .ovf_o(ovf[4]));

   ////////////////////////////////////////////////////////////////////
   // Control registers and overflow status

   // Write one to clear; a fresh overflow in the same cycle survives
   always @* begin
      next_gstat = gstat;
      if (wr_en && paddr_i == `TPSU_GSTAT)
         next_gstat = gstat & ~pwdata_i[4:0];
      next_gstat = next_gstat | ovf;
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         evsel0 <= `TPSU_RESET32;
         evsel1 <= `TPSU_RESET32;
         fctl <= `TPSU_RESET32;
         gstat <= 5'h00;
         smp_en <= 1'b0;
         rsp0 <= `TPSU_RESET32;
         rsp1 <= `TPSU_RESET32;
         lat_en <= 1'b0;
         ds_base <= `TPSU_RESET32;
      end else begin
         gstat <= next_gstat;
         if (wr_en) begin
            if (paddr_i == `TPSU_EVSEL0)
               evsel0 <= pwdata_i & `TPSU_EVS_MASK;
            else if (paddr_i == `TPSU_EVSEL1)
               evsel1 <= pwdata_i & `TPSU_EVS_MASK;
            else if (paddr_i == `TPSU_FCTL)
               fctl <= pwdata_i & `TPSU_FCTL_MASK;
            else if (paddr_i == `TPSU_SMPEN)
               smp_en <= pwdata_i[0];
            else if (paddr_i == `TPSU_RSP0)
               rsp0 <= pwdata_i;
            else if (paddr_i == `TPSU_RSP1)
               rsp1 <= pwdata_i;
            else if (paddr_i == `TPSU_LATC)
               lat_en <= pwdata_i[0];
            else if (paddr_i == `TPSU_DSBASE)
               ds_base <= pwdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB read path

   // Zero wait states: read data is captured in the setup cycle
   assign pready_o = 1'b1;
   assign rd_setup = psel_i && !penable_i;

   always @* begin
      rd_val = 32'h00000000;
      rd_err = 1'b0;
      if (paddr_i == `TPSU_EVSEL0)
         rd_val = evsel0;
      else if (paddr_i == `TPSU_EVSEL1)
         rd_val = evsel1;
      else if (paddr_i == `TPSU_GCTR0)
         rd_val = gc0;
      else if (paddr_i == `TPSU_GCTR1)
         rd_val = gc1;
      else if (paddr_i == `TPSU_FCTR0)
         rd_val = fc0;
      else if (paddr_i == `TPSU_FCTR1)
         rd_val = fc1;
      else if (paddr_i == `TPSU_FCTR2)
         rd_val = fc2;
      else if (paddr_i == `TPSU_FCTL)
         rd_val = fctl;
      else if (paddr_i == `TPSU_GSTAT)
         rd_val = {27'h0, gstat};
      else if (paddr_i == `TPSU_SMPEN)
         rd_val = {31'h0, smp_en};
      else if (paddr_i == `TPSU_CAP)
         rd_val = `TPSU_CAP_VAL;
      else if (paddr_i == `TPSU_VERS)
         rd_val = `TPSU_VERS_VAL;
      else if (paddr_i == `TPSU_RSP0)
         rd_val = rsp0;
      else if (paddr_i == `TPSU_RSP1)
         rd_val = rsp1;
      else if (paddr_i == `TPSU_LATC)
         rd_val = {31'h0, lat_en};
      else if (paddr_i == `TPSU_DSBASE)
         rd_val = ds_base;
      else if (paddr_i == `TPSU_RECST)
         rd_val = {rec_busy_o, 15'h0, rec_idx};
      else
         rd_err = 1'b1;
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else if (rd_setup) begin
         prdata_o <= pwrite_i ? 32'h00000000 : rd_val;
         pslverr_o <= rd_err;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sample records

   // Latest counted event on counter 0; its overflow strobe lags a cycle
   always @(posedge clk_i) begin
      if (srst_i) begin
         eip_q <= 64'h0;
         dla_q <= 64'h0;
         smp_ok_q <= 1'b0;
         dla_ok_q <= 1'b0;
      end else if (hit0) begin
         eip_q <= ev_ip_i;
         dla_q <= ev_dla_i;
         smp_ok_q <= smp_hit;
         dla_ok_q <= dla_hit;
      end
   end

   // Only counter 0 may start a record, and one at a time
   assign trig = ovf[0] && smp_en && smp_ok_q && state == ST_IDLE;
   assign rec_off = {9'h000, rec_idx, 7'h00} + {10'h000, rec_idx, 6'h00};
   assign mem_req_o = state == ST_WR;
   assign rec_busy_o = state != ST_IDLE;

   // Field mux: core state first, then status, address and pointer
   always @* begin
      fld_data = 64'h0;
      if (fld < `TPSU_FLD_ARCH)
         fld_data = st_data_i;
      else if (fld == `TPSU_FLD_GSTAT)
         fld_data = {59'h0, snap_stat};
      else if (fld == `TPSU_FLD_DLA)
         fld_data = snap_dla;
      else if (fld == `TPSU_FLD_EIP)
         fld_data = snap_ip;
   end

   // Record writer: load a field, then hold it until acknowledged
   always @(posedge clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         fld <= 5'h00;
         st_sel_o <= 5'h00;
         rec_idx <= 16'h0000;
         snap_ip <= 64'h0;
         snap_dla <= 64'h0;
         snap_stat <= 5'h00;
         mem_addr_o <= 32'h00000000;
         mem_wdata_o <= 64'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wr_en && paddr_i == `TPSU_DSBASE)
                  rec_idx <= 16'h0000;
               if (trig) begin
                  snap_ip <= eip_q;
                  snap_dla <= dla_ok_q ? dla_q : 64'h0;
                  snap_stat <= gstat | ovf;
                  fld <= 5'h00;
                  st_sel_o <= 5'h00;
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               mem_wdata_o <= fld_data;
               mem_addr_o <= ds_base + rec_off + {24'h0, fld, 3'b000};
               state <= ST_WR;
            end
            ST_WR: begin
               if (mem_ack_i) begin
                  if (fld == `TPSU_FLD_LAST) begin
                     rec_idx <= rec_idx + 16'h0001;
                     state <= ST_IDLE;
                  end else begin
                     fld <= fld + 5'h01;
                     st_sel_o <= fld + 5'h01;
                     state <= ST_LOAD;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// ---- sim/tpsu_checker.sv ----
// Checker for the tile performance sampling unit: identity reads and the
// sample record write sequence.
// Assumes binding to tpsu_top and a core whose st_data_i follows st_sel_o.
`timescale 1ns/1ps
`include "tpsu_map.vh"
module tpsu_checker (
   input logic clk_i,
   input logic srst_i,
   input logic [7:0] paddr_i,
   input logic psel_i,
   input logic penable_i,
   input logic pwrite_i,
   input logic [31:0] pwdata_i,
   input logic [31:0] prdata_o,
   input logic [4:0] st_sel_o,
   input logic [63:0] st_data_i,
   input logic mem_req_o,
   input logic [31:0] mem_addr_o,
   input logic [63:0] mem_wdata_o,
   input logic mem_ack_i,
   input logic rec_busy_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic [4:0] fld;
   logic [31:0] start;
   logic samp_en;
   logic apb_rd;
   assign apb_rd = psel_i && penable_i && !pwrite_i;
   ////////////////////////////////////////////////////////////////////////////
   // Field index follows the acks; cleared whenever the writer idles
   always @(posedge clk_i) begin
      if (srst_i || !rec_busy_o) begin
         fld <= 5'h00;
      end else if (mem_req_o && mem_ack_i) begin
         fld <= fld + 5'h01;
      end
   end
   // Record start address and shadow of the sampling enable
   always @(posedge clk_i) begin
      if (mem_req_o && fld == 5'h00) begin
         start <= mem_addr_o;
      end
      if (srst_i) begin
         samp_en <= 1'b0;
      end else if (psel_i && penable_i && pwrite_i && paddr_i == `TPSU_SMPEN) begin
         samp_en <= pwdata_i[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence s_hold;
      mem_req_o && !mem_ack_i;
   endsequence
   sequence s_load_wr;
      !mem_req_o ##1 mem_req_o;
   endsequence
   AST_CAP_FMT: assert property (apb_rd && paddr_i == `TPSU_CAP |-> prdata_o[11:8] == 4'h2)
      else $error("capability format wrong");
   AST_VERSION: assert property (apb_rd && paddr_i == `TPSU_VERS |->
      prdata_o[19:0] == 20'h30203) else $error("version word wrong");
   AST_HOLD: assert property (s_hold |=> mem_req_o && $stable(mem_addr_o) &&
      $stable(mem_wdata_o)) else $error("record write changed before ack");
   AST_START: assert property ($rose(rec_busy_o) |=> mem_req_o)
      else $error("record write late");
   AST_ENABLED: assert property ($rose(rec_busy_o) |-> samp_en)
      else $error("record while sampling off");
   AST_STEP: assert property (mem_req_o && mem_ack_i && fld != `TPSU_FLD_LAST |=> s_load_wr)
      else $error("field sequence broken");
   AST_ADDR: assert property (mem_req_o && fld != 5'h00 |->
      mem_addr_o == start + {24'h0, fld, 3'h0}) else $error("field address wrong");
   AST_ARCH: assert property (mem_req_o && fld < `TPSU_FLD_ARCH |->
      st_sel_o == fld && mem_wdata_o == st_data_i) else $error("state field wrong");
   AST_RSVD: assert property (mem_req_o && (fld == 5'h14 || fld == 5'h15 ||
      fld == `TPSU_FLD_LAST) |-> mem_wdata_o == 64'h0) else $error("reserved not zero");
   AST_END: assert property (mem_req_o && mem_ack_i && fld == `TPSU_FLD_LAST |=> !rec_busy_o)
      else $error("writer busy after last field");
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the tile performance sampling unit.
// Assumes tpsu_map.vh on the include path; the bench is APB master and core.
`timescale 1ns/1ps
`include "tpsu_map.vh"
module tb;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, mem_addr_o;
   logic pready_o, pslverr_o, mem_req_o, rec_busy_o;
   logic ev_valid_i = 1'b0, mem_ack_i = 1'b0;
   logic [7:0] ev_code_i = 8'h00, ev_umask_i = 8'h00;
   logic [15:0] ev_req_type_i = 16'h0;
   logic [63:0] ev_ip_i = 64'h0, ev_dla_i = 64'h0, st_data_i, mem_wdata_o;
   logic [3:0] outst_i = 4'h0;
   logic instr_ret_i = 1'b0, core_cyc_i = 1'b0, ref_cyc_i = 1'b0;
   logic sib_instr_ret_i = 1'b0, sib_core_cyc_i = 1'b0, sib_ref_cyc_i = 1'b0;
   logic [4:0] st_sel_o;
   logic [63:0] rec [0:23];
   logic [31:0] rec_a;
   logic [15:0] tbl [0:18] = '{16'hc47e, 16'hc4fe, 16'hc4f9, 16'hc4fd, 16'hc4fb,
      16'hc4eb, 16'hc4bf, 16'hc4f7, 16'hc500, 16'hc57e, 16'hc5fe, 16'hc5fb, 16'hc5eb,
      16'hc5f7, 16'h0402, 16'h0404, 16'h0408, 16'h0301, 16'h0308};
   int wcnt = 0, bad_count = 0, tests_run = 0;
   always #50 clk_i = ~clk_i;
   // Core state answer is a pure function of the index, easy to predict
   assign st_data_i = {8'ha5, 51'h0, st_sel_o};
   tpsu_top dut (.clk_i, .srst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .ev_valid_i, .ev_code_i, .ev_umask_i,
      .ev_req_type_i, .ev_ip_i, .ev_dla_i, .outst_i, .instr_ret_i, .core_cyc_i,
      .ref_cyc_i, .sib_instr_ret_i, .sib_core_cyc_i, .sib_ref_cyc_i, .st_sel_o,
      .st_data_i, .mem_req_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .rec_busy_o);
   ////////////////////////////////////////////////////////////////////////////
   // Memory port: accept each write a cycle late so the hold is exercised
   always @(posedge clk_i) begin
      mem_ack_i <= mem_req_o && !mem_ack_i;
      if (mem_req_o && mem_ack_i) begin
         rec[wcnt % 24] <= mem_wdata_o;
         wcnt <= wcnt + 1;
         if (wcnt % 24 == 0)
            rec_a <= mem_addr_o;
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; an idle edge follows so psel never toggles in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic ev(input logic [7:0] c, input logic [7:0] u, input int n);
      ev_code_i <= c;
      ev_umask_i <= u;
      ev_valid_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      ev_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Identity words and a refused address
   task automatic t_ident();
      logic [31:0] q;
      logic e;
      rd(`TPSU_CAP, q);
      chk(64'(q[11:8]), 64'h2);
      rd(`TPSU_VERS, q);
      chk(64'(q[7:0]), 64'h3);
      chk(64'(q[19:8]), 64'h302);
      apb(1'b0, 8'h80, 32'h0, q, e);
      chk(64'(e), 64'h1);
   endtask
   // Event select matching and any-thread on fixed events and general cycle events only
   task automatic t_count();
      logic [31:0] q;
      wr(`TPSU_EVSEL0, 32'h00607ec4);
      ev(8'hc4, 8'h7e, 5);
      ev(8'hc4, 8'hfe, 2);
      rd(`TPSU_GCTR0, q);
      chk(64'(q), 64'd5);
      wr(`TPSU_EVSEL1, 32'h0060003c);
      wr(`TPSU_FCTL, 32'h00000103);
      {core_cyc_i, sib_core_cyc_i, ref_cyc_i, instr_ret_i, sib_instr_ret_i} <= 5'h1f;
      repeat (4) @(posedge clk_i);
      {core_cyc_i, sib_core_cyc_i, ref_cyc_i, instr_ret_i, sib_instr_ret_i} <= 5'h00;
      repeat (3) @(posedge clk_i);
      rd(`TPSU_GCTR1, q);
      chk(64'(q), 64'd8);
      rd(`TPSU_FCTR0, q);
      chk(64'(q), 64'd8);
      rd(`TPSU_FCTR1, q);
      chk(64'(q), 64'd0);
      rd(`TPSU_FCTR2, q);
      chk(64'(q), 64'd4);
   endtask
   // Off-core filtering and latency pairing
   task automatic t_lat();
      logic [31:0] q;
      wr(`TPSU_RSP0, 32'h00000004);
      wr(`TPSU_LATC, 32'h00000001);
      wr(`TPSU_EVSEL0, 32'h004001b7);
      wr(`TPSU_EVSEL1, 32'h00400000);
      wr(`TPSU_GCTR0, 32'h0);
      wr(`TPSU_GCTR1, 32'h0);
      ev_req_type_i <= 16'h0004;
      outst_i <= 4'h3;
      ev(8'hb7, 8'h01, 5);
      outst_i <= 4'h0;
      ev_req_type_i <= 16'h0002;
      ev(8'hb7, 8'h01, 2);
      ev(8'hb7, 8'h02, 2);
      rd(`TPSU_GCTR0, q);
      chk(64'(q), 64'd5);
      // Three outstanding over five event edges and the three idle edges after
      rd(`TPSU_GCTR1, q);
      chk(64'(q), 64'd24);
      wr(`TPSU_RSP1, 32'h00000002);
      wr(`TPSU_EVSEL0, 32'h004002b7);
      ev(8'hb7, 8'h02, 3);
      ev(8'hb7, 8'h01, 2);
      rd(`TPSU_GCTR0, q);
      chk(64'(q), 64'd8);
      wr(`TPSU_LATC, 32'h0);
      wr(`TPSU_EVSEL1, 32'h0);
   endtask
   // One record per supported event and mask except C4H mask 00H, contents checked field by field
   task automatic t_rec();
      logic [31:0] q;
      logic [63:0] ip;
      logic [63:0] dla;
      int n0;
      wr(`TPSU_DSBASE, 32'h00001000);
      wr(`TPSU_SMPEN, 32'h00000001);
      for (int i = 0; i < 19; i++) begin
         n0 = wcnt;
         ip = 64'h0000700000000000 + 64'(i);
         dla = 64'hffff800000000000 + 64'(i);
         wr(`TPSU_GSTAT, 32'h0000001f);
         wr(`TPSU_EVSEL0, {16'h0040, tbl[i][7:0], tbl[i][15:8]});
         wr(`TPSU_GCTR0, 32'hffffffff);
         ev_ip_i <= ip;
         ev_dla_i <= dla;
         ev(tbl[i][15:8], tbl[i][7:0], 1);
         while (wcnt < n0 + 24) @(posedge clk_i);
         repeat (3) @(posedge clk_i);
         for (int k = 0; k < 18; k++) chk(rec[k], {8'ha5, 51'h0, 5'(k)});
         chk(64'(rec[18][0]), 64'h1);
         chk(rec[19], (tbl[i][15:8] < 8'h05) ? dla : 64'h0);
         chk(rec[20] | rec[21] | rec[23], 64'h0);
         chk(rec[22], ip);
         chk(64'(rec_a), 64'h1000 + 64'(i) * 64'(`TPSU_REC_BYTES));
      end
      rd(`TPSU_RECST, q);
      chk(64'(q[15:0]), 64'd19);
   endtask
   // Overflows that must not produce a record
   task automatic t_norec();
      logic [31:0] q;
      int n0;
      n0 = wcnt;
      wr(`TPSU_GSTAT, 32'h0000001f);
      wr(`TPSU_SMPEN, 32'h0);
      wr(`TPSU_EVSEL0, 32'h00407ec4);
      wr(`TPSU_GCTR0, 32'hffffffff);
      ev(8'hc4, 8'h7e, 1);
      wr(`TPSU_SMPEN, 32'h00000001);
      wr(`TPSU_EVSEL0, 32'h0040412e);
      wr(`TPSU_GCTR0, 32'hffffffff);
      ev(8'h2e, 8'h41, 1);
      repeat (60) @(posedge clk_i);
      chk(64'(wcnt), 64'(n0));
      wr(`TPSU_EVSEL0, 32'h0);
      wr(`TPSU_EVSEL1, 32'h00407ec4);
      wr(`TPSU_GCTR1, 32'hffffffff);
      ev(8'hc4, 8'h7e, 1);
      repeat (60) @(posedge clk_i);
      chk(64'(wcnt), 64'(n0));
      rd(`TPSU_GSTAT, q);
      chk(64'(q[1:0]), 64'h3);
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      t_ident();
      t_count();
      t_lat();
      t_rec();
      t_norec();
      wrap_up();
   end
   // Watchdog, far beyond the few thousand cycles the run needs
   initial begin
      #2000000;
      bad_count++;
      wrap_up();
   end
endmodule
bind tpsu_top tpsu_checker u_chk (.clk_i, .srst_i, .paddr_i, .psel_i, .penable_i,
   .pwrite_i, .pwdata_i, .prdata_o, .st_sel_o, .st_data_i, .mem_req_o, .mem_addr_o,
   .mem_wdata_o, .mem_ack_i, .rec_busy_o);
